// >>> include/phy_page_defs.svh
// Purpose: constants for the paged extension registers of a cable PHY
// Assumes: APB word per register, byte address = 4 x register index
// Notes:   Overview list below is kept in step with the tags in rtl/
//
// Overview of operation
// R1 - page-select value 7 maps the vendor-dependent control page into window
// R2 - page-select value 1 maps the identification page into the window
// R3 - identification page returns read-only compliance byte 01h
// R4 - read-only 24-bit vendor OUI over three bytes, MSB at index 1010b
// R5 - read-only 24-bit product identifier, MSB at index 1101b
// R6 - flag set with acceleration: only packets over 8 bits clear requests
// R7 - flag clear: any non-acknowledge packet clears fair and priority requests
// R8 - null-packet flag resets to 0 and survives bus resets
// R9 - link speed codes 00 S100, 01 S200, 10 S400, 11 illegal
// R10 - link speed is copied into the self-ID speed subfield
// R11 - speed signalled to peer PHYs during self-ID is always S400
// R12 - hard reset sets link speed to 10b; bus reset leaves it
// R13 - writing 1 to soft hard reset bit forces a full hard reset
// R14 - soft hard reset bit always reads back as 0
// R15 - power-class straps give default power class of self-ID bits 21-23
// R16 - straps load after hard reset; later register 4 writes override
// R17 - writes to identification or test bits change nothing documented
`ifndef PHY_PAGE_DEFS_SVH
`define PHY_PAGE_DEFS_SVH

// register indices (byte address is index times four)
`define PG_IDX_PWR     4'h4
`define PG_IDX_ACCEL   4'h5
`define PG_IDX_PAGE    4'h7
`define PG_IDX_CTRL    4'h8
`define PG_IDX_COMPL   4'h8
`define PG_IDX_OUI     4'ha
`define PG_IDX_PROD    4'hd
`define PG_IDX_HRST    4'he

// page-select values
`define PG_PAGE_IDENT  3'h1
`define PG_PAGE_VENDOR 3'h7

// field positions inside the byte
`define PG_NULL_BIT    3'h7
`define PG_HRST_BIT    3'h7
`define PG_ACCEL_BIT   3'h0

// reset and fixed values
`define PG_NULL_RST    1'h0
`define PG_LSPD_RST    2'h2
`define PG_LSPD_ILL    2'h3
`define PG_PAGE_RST    3'h0
`define PG_COMPL_VAL   8'h01
`define PG_PEER_S400   3'h2
`define PG_ACK_BITS    8'h08

`endif

// >>> include/phy_page_pkg.sv
// Purpose: shared types of the paged register block
// Assumes: constants live in phy_page_defs.svh
// Notes:   one-hot codes are written out for the bus state machine
package phy_page_pkg;

	typedef enum logic [2:0] {
		st_idle  = 3'h1,
		st_fetch = 3'h2,
		st_resp  = 3'h4
	} apb_state_t;

	typedef enum logic [1:0] {
		spd_s100 = 2'h0,
		spd_s200 = 2'h1,
		spd_s400 = 2'h2
	} link_speed_t;

endpackage

// >>> rtl/ident_rom.sv
// Purpose: identification page contents with registered read data
// Assumes: addr is the low three bits of the register index
// Notes:   identity values are parameters so a product can set them
`timescale 1ns/100ps
`include "phy_page_defs.svh"

module ident_rom #(
	parameter logic [23:0] VENDOR_OUI = 24'h5a_c3e1, // arbitrary
	parameter logic [23:0] PRODUCT_IDENT_BYTES = 24'h3c_0a71  // arbitrary
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [2:0] addr,
	output logic      [7:0] data_q
);

	logic [7:0] data_d;

	// index 1001b is reserved and reads zero
	always_comb
	begin
		case (addr)
			3'h0:    data_d = `PG_COMPL_VAL;    // [R3]
			3'h2:    data_d = VENDOR_OUI[23:16]; // [R4]
			3'h3:    data_d = VENDOR_OUI[15:8];
			3'h4:    data_d = VENDOR_OUI[7:0];
			3'h5:    data_d = PRODUCT_IDENT_BYTES[23:16]; // [R5]
			3'h6:    data_d = PRODUCT_IDENT_BYTES[15:8];
			3'h7:    data_d = PRODUCT_IDENT_BYTES[7:0];
			default: data_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			data_q <= 8'h00;
		else if (ce)
			data_q <= data_d;
	end

endmodule

// >>> rtl/phy_vendor_page_registers.sv
// Purpose: paged extension registers of a two-port cable PHY over APB
// Assumes: packet length and request events come from arbitration logic
// Notes:   two wait states on every access; unmapped words give pslverr
`timescale 1ns/100ps
`include "phy_page_defs.svh"

module phy_vendor_page_registers
	import phy_page_pkg::*;
#(
	parameter logic [23:0] VENDOR_OUI = 24'h5a_c3e1, // arbitrary
	parameter logic [23:0] PRODUCT_IDENT_BYTES = 24'h3c_0a71  // arbitrary
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  power_class_straps,
	input  wire logic        rx_pkt_done,
	input  wire logic [7:0]  rx_pkt_bits,
	input  wire logic        fair_req_set,
	input  wire logic        pri_req_set,
	output logic             fair_req_pending_q,
	output logic             pri_req_pending_q,
	output logic      [1:0]  selfid_speed_subfield_q,
	output logic      [2:0]  selfid_pwr_class_q,
	output logic      [2:0]  peer_speed_q,
	output logic             phy_hard_reset_q
);

	apb_state_t  state_q;
	logic [2:0]  page_q;
	logic [2:0]  pwr_class_q;
	logic        accel_q;
	logic        null_packet_action_flag_q;
	link_speed_t link_speed_q;
	logic        strap_load_q;
	logic [7:0]  rom_q;
	logic [7:0]  rd_byte;
	logic [3:0]  idx;
	logic        aligned;
	logic        mapped;
	logic        access;
	logic        wr_done;
	logic        pg_ident;
	logic        pg_vendor;
	logic        hrst_hit;
	logic        req_clear;

	// decode is purely from the held request, which stays stable
	assign idx       = paddr[5:2];
	assign aligned   = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
	assign mapped    = aligned && (idx[3] || idx == `PG_IDX_PWR ||
	                   idx == `PG_IDX_ACCEL || idx == `PG_IDX_PAGE);
	assign access    = psel && penable;
	assign wr_done   = (state_q == st_resp) && access && pwrite && mapped;
	assign pg_ident  = (page_q == `PG_PAGE_IDENT);
	assign pg_vendor = (page_q == `PG_PAGE_VENDOR);
	assign hrst_hit  = wr_done && pg_vendor && idx == `PG_IDX_HRST &&
	                   pwdata[`PG_HRST_BIT];

	ident_rom #(
		.VENDOR_OUI (VENDOR_OUI),
		.PRODUCT_IDENT_BYTES (PRODUCT_IDENT_BYTES)
	) ident_rom_i (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.addr   (idx[2:0]),
		.data_q (rom_q)
	);

	// read mux; the window shows nothing for pages not built here
	always_comb
	begin
		rd_byte = 8'h00;
		if (idx[3])
		begin
			if (pg_ident)
				rd_byte = rom_q; // [R2]
			else if (pg_vendor && idx == `PG_IDX_CTRL)
			begin
				rd_byte[`PG_NULL_BIT] = null_packet_action_flag_q; // [R1]
				rd_byte[1:0]         = link_speed_q;
			end
			// soft hard reset and test bytes read zero [R14] [R17]
		end
		else if (idx == `PG_IDX_PWR)
			rd_byte[2:0] = pwr_class_q;
		else if (idx == `PG_IDX_ACCEL)
			rd_byte[`PG_ACCEL_BIT] = accel_q;
		else if (idx == `PG_IDX_PAGE)
			rd_byte[2:0] = page_q;
	end

	// bus state machine; the extra fetch cycle lets the rom settle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= st_idle;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (ce)
		begin
			case (state_q)
				st_idle:
				begin
					pready  <= 1'b0;
					pslverr <= 1'b0;
					if (access)
						state_q <= st_fetch;
				end
				st_fetch:
				begin
					prdata  <= (pwrite || !mapped) ? 32'h0000_0000
					           : {24'h00_0000, rd_byte};
					pslverr <= !mapped;
					pready  <= 1'b1;
					state_q <= st_resp;
				end
				st_resp:
				begin
					pready  <= 1'b0;
					pslverr <= 1'b0;
					state_q <= st_idle;
				end
				default:
				begin
					pready  <= 1'b0;
					pslverr <= 1'b0;
					state_q <= st_idle;
				end
			endcase
		end
	end

	// soft hard reset pulse, also used as the internal hard reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			phy_hard_reset_q <= 1'b0;
		else if (ce)
			phy_hard_reset_q <= hrst_hit; // [R13]
	end

	// page select and plain control bytes
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			page_q  <= `PG_PAGE_RST;
			accel_q <= 1'b0;
		end
		else if (ce)
		begin
			if (phy_hard_reset_q)
			begin
				page_q  <= `PG_PAGE_RST;
				accel_q <= 1'b0;
			end
			else if (wr_done && idx == `PG_IDX_PAGE)
				page_q <= pwdata[2:0]; // [R1] [R2]
			else if (wr_done && idx == `PG_IDX_ACCEL)
				accel_q <= pwdata[`PG_ACCEL_BIT];
		end
	end

	// vendor control byte; bus reset has no path in here [R8] [R12]
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			null_packet_action_flag_q <= `PG_NULL_RST;
			link_speed_q              <= link_speed_t'(`PG_LSPD_RST);
		end
		else if (ce)
		begin
			if (phy_hard_reset_q)
			begin
				null_packet_action_flag_q <= `PG_NULL_RST; // [R13]
				link_speed_q <= link_speed_t'(`PG_LSPD_RST);
			end
			else if (wr_done && pg_vendor && idx == `PG_IDX_CTRL)
			begin
				null_packet_action_flag_q <= pwdata[`PG_NULL_BIT];
				// the illegal code is refused, field keeps its value
				if (pwdata[1:0] != `PG_LSPD_ILL)
					link_speed_q <= link_speed_t'(pwdata[1:0]); // [R9]
			end
		end
	end

	// straps are caught a cycle after either reset, never under it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			strap_load_q <= 1'b1;
			pwr_class_q  <= 3'h0;
		end
		else if (ce)
		begin
			strap_load_q <= phy_hard_reset_q;
			if (wr_done && idx == `PG_IDX_PWR)
				pwr_class_q <= pwdata[2:0]; // [R16]
			else if (strap_load_q)
				pwr_class_q <= power_class_straps; // [R15] [R16]
		end
	end

	// an 8-bit packet is an acknowledge and never clears
	always_comb
	begin
		if (null_packet_action_flag_q && accel_q)
			req_clear = rx_pkt_done && rx_pkt_bits > `PG_ACK_BITS; // [R6]
		else
			req_clear = rx_pkt_done && rx_pkt_bits != `PG_ACK_BITS; // [R7]
	end

	// a new request in the clearing cycle stays pending
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fair_req_pending_q <= 1'b0;
			pri_req_pending_q  <= 1'b0;
		end
		else if (ce)
		begin
			if (phy_hard_reset_q)
			begin
				fair_req_pending_q <= 1'b0;
				pri_req_pending_q  <= 1'b0;
			end
			else
			begin
				fair_req_pending_q <= fair_req_set ||
				                      (fair_req_pending_q && !req_clear);
				pri_req_pending_q  <= pri_req_set ||
				                      (pri_req_pending_q && !req_clear);
			end
		end
	end

	// self-ID fields follow the registers one cycle later
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selfid_speed_subfield_q <= `PG_LSPD_RST;
			selfid_pwr_class_q      <= 3'h0;
			peer_speed_q            <= `PG_PEER_S400;
		end
		else if (ce)
		begin
			selfid_speed_subfield_q <= link_speed_q; // [R10]
			selfid_pwr_class_q      <= pwr_class_q; // [R15]
			peer_speed_q            <= `PG_PEER_S400; // [R11]
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence rd_fetch(logic [2:0] pg, logic [3:0] ix);
		ce && state_q == st_fetch && !pwrite && aligned &&
		page_q == pg && idx == ix;
	endsequence

	sequence hrst_write;
		ce && hrst_hit ##1 ce && phy_hard_reset_q;
	endsequence

	page7_map_a: assert property ( // [R1]
		rd_fetch(`PG_PAGE_VENDOR, `PG_IDX_CTRL) |=>
		prdata[7] == $past(null_packet_action_flag_q) &&
		prdata[1:0] == $past(link_speed_q) && pready)
		else $error("vendor page control byte read wrong");

	ident_compl_a: assert property ( // [R2]
		rd_fetch(`PG_PAGE_IDENT, `PG_IDX_COMPL) ##1 ce |->
		prdata == 32'h0000_0001)
		else $error("compliance byte read wrong");

	vendor_msb_a: assert property ( // [R4]
		rd_fetch(`PG_PAGE_IDENT, `PG_IDX_OUI) |=>
		prdata[7:0] == VENDOR_OUI[23:16])
		else $error("vendor oui msb read wrong");

	product_msb_a: assert property ( // [R5]
		rd_fetch(`PG_PAGE_IDENT, `PG_IDX_PROD) |=>
		prdata[7:0] == PRODUCT_IDENT_BYTES[23:16])
		else $error("product_ident_bytes msb read wrong");

	null_hold_a: assert property ( // [R6]
		ce && null_packet_action_flag_q && accel_q && rx_pkt_done &&
		rx_pkt_bits <= `PG_ACK_BITS && fair_req_pending_q &&
		!phy_hard_reset_q |=> fair_req_pending_q)
		else $error("short packet cleared request with flag set");

	null_clear_a: assert property ( // [R7]
		ce && !null_packet_action_flag_q && rx_pkt_done &&
		rx_pkt_bits != `PG_ACK_BITS && !pri_req_set |=>
		!pri_req_pending_q)
		else $error("non-ack packet left request pending");

	ack_keep_a: assert property ( // [R7]
		ce && rx_pkt_done && rx_pkt_bits == `PG_ACK_BITS &&
		pri_req_pending_q && !phy_hard_reset_q |=> pri_req_pending_q)
		else $error("acknowledge cleared a request");

	speed_copy_a: assert property ( // [R10]
		ce ##1 ce |-> selfid_speed_subfield_q == $past(link_speed_q))
		else $error("self-ID speed not following link speed");

	peer_s400_a: assert property ( // [R11]
		peer_speed_q == `PG_PEER_S400)
		else $error("peer speed not S400");

	soft_reset_a: assert property ( // [R13]
		hrst_write ##1 ce |->
		link_speed_q == spd_s400 && !null_packet_action_flag_q &&
		page_q == `PG_PAGE_RST)
		else $error("soft hard reset did not reset registers");

	soft_read_a: assert property ( // [R14]
		rd_fetch(`PG_PAGE_VENDOR, `PG_IDX_HRST) |=> prdata == 32'h0)
		else $error("soft hard reset bit read nonzero");

	strap_load_a: assert property ( // [R16]
		hrst_write ##1 (ce && !wr_done) ##1 ce |->
		pwr_class_q == $past(power_class_straps))
		else $error("straps not loaded after hard reset");

	test_write_a: assert property ( // [R17]
		ce && wr_done && idx[3] && idx != `PG_IDX_CTRL |=>
		$stable(link_speed_q) && $stable(null_packet_action_flag_q))
		else $error("test byte write changed control");

endmodule

// >>> verif/llc_pkt_model.sv
// Purpose: link-side source of packet and request events for the bench
// Assumes: events launched just after a rising edge, one cycle each
// Notes:   bit count is scrambled outside the done pulse
`timescale 1ns/100ps
module llc_pkt_model (
	input  wire logic       clk,
	output logic            rx_pkt_done,
	output logic      [7:0] rx_pkt_bits,
	output logic            fair_req_set,
	output logic            pri_req_set
);
	initial
	begin
		rx_pkt_done = 1'b0;
		rx_pkt_bits = 8'h5a;
		fair_req_set = 1'b0;
		pri_req_set = 1'b0;
	end
	task automatic raise_reqs();
		@(posedge clk);
		fair_req_set <= 1'b1;
		pri_req_set <= 1'b1;
		@(posedge clk);
		fair_req_set <= 1'b0;
		pri_req_set <= 1'b0;
	endtask
	// count is only meaningful with done, so it must not linger
	task automatic send_pkt(input logic [7:0] b);
		@(posedge clk);
		rx_pkt_done <= 1'b1;
		rx_pkt_bits <= b;
		@(posedge clk);
		rx_pkt_done <= 1'b0;
		rx_pkt_bits <= ~b;
	endtask
endmodule

// >>> verif/phy_vendor_page_registers_tb.sv
// Purpose: self-checking bench for the paged extension registers
// Assumes: apb answers with pready; straps steady around resets
// Notes:   identity values below are arbitrary
`timescale 1ns/100ps
module phy_vendor_page_registers_tb;
	import phy_page_pkg::*;
	localparam logic [23:0] OUI  = 24'h9b_4d26; // arbitrary
	localparam logic [23:0] PROD = 24'h61_e8f0; // arbitrary
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  straps;
	logic        done;
	logic [7:0]  bits;
	logic        fset;
	logic        pset;
	logic        fpend;
	logic        ppend;
	logic [1:0]  spd;
	logic [2:0]  pwr;
	logic [2:0]  peer;
	logic        hrst;
	int          num_errors;
	int          checks;
	logic [63:0] idp;
	logic [31:0] rd;
	logic        er;

	phy_vendor_page_registers #(
		.VENDOR_OUI(OUI),
		.PRODUCT_IDENT_BYTES(PROD)
	) phy_vendor_page_registers_i (
		.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_class_straps(straps),
		.rx_pkt_done(done), .rx_pkt_bits(bits), .fair_req_set(fset),
		.pri_req_set(pset), .fair_req_pending_q(fpend),
		.pri_req_pending_q(ppend), .selfid_speed_subfield_q(spd),
		.selfid_pwr_class_q(pwr), .peer_speed_q(peer),
		.phy_hard_reset_q(hrst)
	);
	llc_pkt_model llc_pkt_model_i (
		.clk(clk), .rx_pkt_done(done), .rx_pkt_bits(bits),
		.fair_req_set(fset), .pri_req_set(pset)
	);

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// answer is read at the rising edge itself; the design updates its
	// outputs after that edge, so these are the values of the ending cycle
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int   n;
		logic rdy;
		n = 0;
		rdy = 1'b0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		rdy = pready;
		rd = prdata;
		er = pslverr;
		chk("pready", 1, rdy);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk("pslverr", 0, er);
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("pslverr", 0, er);
		chk(n, e, rd);
	endtask
	task automatic pkt(input logic [7:0] b, input logic keep);
		llc_pkt_model_i.raise_reqs();
		llc_pkt_model_i.send_pkt(b);
		@(negedge clk);
		chk("pending", keep ? 2'h3 : 2'h0, {fpend, ppend});
	endtask

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		chk("watchdog", 0, 1);
		give_verdict();
	end
	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		straps = 3'h3;
		num_errors = 0;
		checks = 0;
		idp = {8'h01, 8'h00, OUI, PROD};
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(negedge clk);
		chk("peer", 3'h2, peer);
		chk("selfid spd", spd_s400, spd);
		chk("pwr class", 3'h3, pwr);
		rdc("pwr reg", 8'h10, 32'h3);
		rdc("page", 8'h1c, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk("unmapped err", 1, er);
		apb(1'b1, 8'h18, 32'hff);
		chk("idx6 err", 1, er);
		apb(1'b0, 8'h21, 32'h0);
		chk("unaligned err", 1, er);
		wr(8'h1c, 32'h1);
		for (int i = 0; i < 8; i++)
			rdc("ident", 8'(8'h20 + 4 * i), idp[63 - 8 * i -: 8]);
		wr(8'h28, 32'hff);
		wr(8'h20, 32'hff);
		rdc("oui msb", 8'h28, OUI[23:16]);
		rdc("compl", 8'h20, 32'h01);
		wr(8'h1c, 32'h7);
		rdc("ctrl", 8'h20, 32'h02);
		for (int i = 2; i >= 0; i--)
		begin
			wr(8'h20, 32'(i));
			rdc("lspd", 8'h20, 32'(i));
			repeat (2) @(negedge clk);
			chk("selfid spd", 32'(i), spd);
			chk("peer", 3'h2, peer);
		end
		wr(8'h20, 32'h3);
		rdc("lspd ill", 8'h20, 32'h0);
		wr(8'h24, 32'hff);
		wr(8'h38, 32'h7f);
		rdc("ctrl", 8'h20, 32'h0);
		rdc("soft rst", 8'h38, 32'h0);
		pkt(8'h00, 1'b0);
		pkt(8'h05, 1'b0);
		pkt(8'h08, 1'b1);
		pkt(8'hc8, 1'b0);
		wr(8'h20, 32'h80);
		pkt(8'h00, 1'b0);
		wr(8'h14, 32'h1);
		pkt(8'h00, 1'b1);
		pkt(8'h08, 1'b1);
		pkt(8'h05, 1'b1);
		pkt(8'h09, 1'b0);
		rdc("ctrl null flag", 8'h20, 32'h80);
		wr(8'h10, 32'h5);
		repeat (2) @(negedge clk);
		chk("pwr class", 3'h5, pwr);
		@(posedge clk);
		straps <= 3'h6;
		wr(8'h38, 32'h80);
		@(negedge clk);
		chk("hard reset", 1, hrst);
		@(negedge clk);
		chk("hard reset", 0, hrst);
		repeat (4) @(negedge clk);
		chk("pwr class", 3'h6, pwr);
		chk("selfid spd", spd_s400, spd);
		rdc("page", 8'h1c, 32'h0);
		give_verdict();
	end
endmodule
